//--- pct_top.sv
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Function
// - enable loads pointer from start index
// - disable stops and clears all status
// - single mode stops after first match
// - single mode counter keeps accumulating
// - cycle mode reloads pointer with start
// - cycle mode clears counter each match
// - N-cycle counts cycles then switches off
// - match emits pulse of programmed width
// - 42 targets with direction attributes
// - start index picks first target
// - end index picks last target
// - origin trigger loads offset into counter
// - positive attribute fires only increasing
// - detection suspended while pulse active
// - stopping on target gives one pulse
// - pulse or flip output mode
// - route to six outputs or encoder outputs
// - delay compensation before output
// - source motor or external encoder
module pct_top
   import pct_pkg::*;
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Register bus.
   input wire pct_pkg::pct_ahb_in_t ahb_in,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Position sources.
   input wire pct_pkg::pct_pos_in_t pos_in,
   // Compare outputs.
   output pct_pkg::pct_out_t compare_output_function
);
   import pct_pkg::*;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [PCT_CNT_W-1:0] width;
      logic [PCT_CNT_W-1:0] delay;
      logic [PCT_IDX_W-1:0] start_idx;
      logic [PCT_IDX_W-1:0] end_idx;
      logic signed [PCT_POS_W-1:0] origin;
      logic [PCT_CNT_W-1:0] cycles;
      logic signed [PCT_POS_W-1:0] cnt;
      logic signed [PCT_POS_W-1:0] last_src;
      logic [PCT_IDX_W-1:0] ptr;
      logic [PCT_CNT_W-1:0] done_cycles;
      pct_run_t run;
      logic [PCT_CNT_W-1:0] dly_cnt;
      logic [PCT_CNT_W-1:0] pw_cnt;
      logic flip_lvl;
      logic dph_wr;
      logic dph_rd;
      logic [11:0] dph_addr;
      logic [31:0] rdata;
      pct_out_t out;
   } pct_state_t;

   pct_state_t st_r, st_nxt;
   logic signed [PCT_POS_W-1:0] tval_r [PCT_NUM_TARGETS];
   logic [1:0] tattr_r [PCT_NUM_TARGETS];

   function automatic logic idx_ok(input logic [PCT_IDX_W-1:0] i);
      return (i >= 6'h01) && (i <= 6'h2A);
   endfunction

   function automatic logic [PCT_IDX_W-1:0] tix(input logic [11:0] a);
      return a[7:2];
   endfunction

   logic signed [PCT_POS_W-1:0] src_pos, cur_cnt, tgt;
   logic [1:0] attr;
   logic cross_up, cross_dn, hit, busy, fire, last_tgt;
   logic [PCT_IDX_W-1:0] pi;
   pct_mode_t mode;
   logic tbl_val, tbl_attr;

   assign mode = pct_mode_t'(st_r.ctrl[PCT_CTRL_MODE +: 2]);
   assign src_pos = st_r.ctrl[PCT_CTRL_SRC] ? pos_in.ext_pos
                                            : pos_in.motor_pos;
   assign cur_cnt = st_r.cnt + (src_pos - st_r.last_src);
   assign pi = idx_ok(st_r.ptr) ? st_r.ptr - 6'h01 : 6'h00;
   assign tgt = tval_r[pi];
   assign attr = tattr_r[pi];
   // Crossing counts when the previous sample is strictly on one side and
   // the new one reaches or passes the target, so resting on it fires once.
   assign cross_up = (st_r.cnt < tgt) && (cur_cnt >= tgt);
   assign cross_dn = (st_r.cnt > tgt) && (cur_cnt <= tgt);
   assign hit = (cross_up && attr[0]) || (cross_dn && attr[1]);
   assign busy = (st_r.dly_cnt != '0) || (st_r.pw_cnt != '0);
   assign fire = (st_r.run == PCT_RUN) && hit && !busy;
   assign last_tgt = (st_r.ptr == st_r.end_idx);
   assign tbl_val = (ahb_in.haddr[11:8] == 4'h1) && idx_ok(
      ahb_in.haddr[7:2] + 6'h01);
   assign tbl_attr = (ahb_in.haddr[11:8] == 4'h2) && idx_ok(
      ahb_in.haddr[7:2] + 6'h01);

   always_comb begin
      st_nxt = st_r;
      st_nxt.last_src = src_pos;
      st_nxt.cnt = cur_cnt;
      st_nxt.dph_wr = 1'b0;
      st_nxt.dph_rd = 1'b0;
      // Delay compensation runs first, then the pulse width counter.
      if (st_r.dly_cnt != '0) begin
         st_nxt.dly_cnt = st_r.dly_cnt - 16'h0001;
         if (st_r.dly_cnt == 16'h0001) begin
            st_nxt.pw_cnt = (st_r.width == '0) ? 16'h0001 : st_r.width;
            st_nxt.flip_lvl = ~st_r.flip_lvl;
         end
      end else if (st_r.pw_cnt != '0) begin
         st_nxt.pw_cnt = st_r.pw_cnt - 16'h0001;
      end
      if (fire) begin
         if (st_r.delay == '0) begin
            st_nxt.pw_cnt = (st_r.width == '0) ? 16'h0001 : st_r.width;
            st_nxt.flip_lvl = ~st_r.flip_lvl;
         end else begin
            st_nxt.dly_cnt = st_r.delay;
         end
         if (mode == PCT_SINGLE) begin
            // The counter is left alone here so that it stays absolute.
            st_nxt.run = PCT_IDLE;
            st_nxt.ptr = '0;
         end else begin
            st_nxt.cnt = '0;
            if (last_tgt) begin
               st_nxt.ptr = st_r.start_idx;
               if (mode == PCT_NCYCLE) begin
                  st_nxt.done_cycles = st_r.done_cycles + 16'h0001;
                  if (st_r.done_cycles + 16'h0001 >= st_r.cycles) begin
                     st_nxt.run = PCT_IDLE;
                     st_nxt.ctrl[PCT_CTRL_EN] = 1'b0;
                  end
               end
            end else begin
               st_nxt.ptr = st_r.ptr + 6'h01;
            end
         end
      end
      if (st_r.ctrl[PCT_CTRL_ORIGIN]) begin
         st_nxt.cnt = st_r.origin;
         st_nxt.ctrl[PCT_CTRL_ORIGIN] = 1'b0;
      end
      // Register writes land in the data phase.
      if (st_r.dph_wr) begin
         unique case (st_r.dph_addr)
            PCT_OFF_CTRL: begin
               st_nxt.ctrl = ahb_in.hwdata[15:0];
               if (ahb_in.hwdata[PCT_CTRL_EN] && !st_r.ctrl[PCT_CTRL_EN]) begin
                  st_nxt.run = PCT_RUN;
                  st_nxt.ptr = st_r.start_idx;
                  st_nxt.done_cycles = '0;
               end
               if (!ahb_in.hwdata[PCT_CTRL_EN]) begin
                  st_nxt.run = PCT_IDLE;
                  st_nxt.ptr = '0;
                  st_nxt.done_cycles = '0;
                  st_nxt.dly_cnt = '0;
                  st_nxt.pw_cnt = '0;
                  st_nxt.flip_lvl = 1'b0;
               end
            end
            PCT_OFF_WIDTH: st_nxt.width = ahb_in.hwdata[15:0];
            PCT_OFF_DELAY: st_nxt.delay = ahb_in.hwdata[15:0];
            PCT_OFF_START: st_nxt.start_idx = ahb_in.hwdata[5:0];
            PCT_OFF_END: st_nxt.end_idx = ahb_in.hwdata[5:0];
            PCT_OFF_ORIGIN: st_nxt.origin = ahb_in.hwdata;
            PCT_OFF_CYCLES: st_nxt.cycles = ahb_in.hwdata[15:0];
            default: ;
         endcase
      end
      // Read data is captured at the address phase.
      if (ahb_in.hsel && ahb_in.hready && ahb_in.htrans[1]) begin
         st_nxt.dph_wr = ahb_in.hwrite;
         st_nxt.dph_rd = !ahb_in.hwrite;
         st_nxt.dph_addr = ahb_in.haddr[11:0];
         unique case (ahb_in.haddr[11:0])
            PCT_OFF_CTRL: st_nxt.rdata = {16'h0000, st_r.ctrl};
            PCT_OFF_WIDTH: st_nxt.rdata = {16'h0000, st_r.width};
            PCT_OFF_DELAY: st_nxt.rdata = {16'h0000, st_r.delay};
            PCT_OFF_START: st_nxt.rdata = {26'h0, st_r.start_idx};
            PCT_OFF_END: st_nxt.rdata = {26'h0, st_r.end_idx};
            PCT_OFF_ORIGIN: st_nxt.rdata = st_r.origin;
            PCT_OFF_CYCLES: st_nxt.rdata = {16'h0000, st_r.cycles};
            PCT_OFF_POS: st_nxt.rdata = st_r.cnt;
            PCT_OFF_STATUS: st_nxt.rdata = {8'h00, st_r.done_cycles,
               st_r.ptr, busy, st_r.run == PCT_RUN};
            default: begin
               st_nxt.rdata = 32'h0000_0000;
               if (tbl_val) begin
                  st_nxt.rdata = tval_r[tix(ahb_in.haddr[11:0])];
               end else if (tbl_attr) begin
                  st_nxt.rdata = {30'h0, tattr_r[tix(ahb_in.haddr[11:0])]};
               end
            end
         endcase
      end
      // Output mapping with polarity per destination.
      begin
         logic act;
         act = st_r.ctrl[PCT_CTRL_FLIP] ? st_nxt.flip_lvl
                                        : (st_nxt.pw_cnt != '0);
         for (int k = 0; k < 6; k++) begin
            st_nxt.out.dout[k] = st_r.ctrl[PCT_CTRL_DOPOL + k] ^
               (act && (st_r.ctrl[PCT_CTRL_ROUTE +: 3] == 3'(k + 1)));
         end
         st_nxt.out.enc_out = {3{st_r.ctrl[PCT_CTRL_ENCPOL] ^
            (act && (st_r.ctrl[PCT_CTRL_ROUTE +: 3] == 3'h7))}};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
         st_r.ctrl <= PCT_CTRL_RST;
         st_r.width <= PCT_WIDTH_RST;
         st_r.delay <= PCT_DELAY_RST;
         st_r.start_idx <= PCT_START_RST;
         st_r.end_idx <= PCT_END_RST;
         st_r.run <= PCT_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Target table is a plain memory, written in the data phase.
   always_ff @(posedge hclk) begin
      if (st_r.dph_wr && idx_ok(st_r.dph_addr[7:2] + 6'h01)) begin
         if (st_r.dph_addr[11:8] == 4'h1) begin
            tval_r[tix(st_r.dph_addr)] <= ahb_in.hwdata;
         end
         if (st_r.dph_addr[11:8] == 4'h2) begin
            tattr_r[tix(st_r.dph_addr)] <= ahb_in.hwdata[1:0];
         end
      end
   end

   assign hrdata = st_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign compare_output_function = st_r.out;

   disable_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.dph_wr && st_r.dph_addr == PCT_OFF_CTRL
      && !ahb_in.hwdata[PCT_CTRL_EN] |=> st_r.run == PCT_IDLE)
      else $error("disable did not stop compare");
   enable_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.dph_wr && st_r.dph_addr == PCT_OFF_CTRL && !st_r.ctrl[0]
      && ahb_in.hwdata[0] |=> st_r.ptr == $past(st_r.start_idx))
      else $error("enable did not load start index");
   busy_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
      busy |-> !fire)
      else $error("detection during active pulse");
   cycle_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && mode != PCT_SINGLE && !st_r.ctrl[PCT_CTRL_ORIGIN]
      |=> st_r.cnt == 32'h0000_0000)
      else $error("cycle counter not cleared");
   single_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && mode == PCT_SINGLE && !st_r.dph_wr
      |=> st_r.run == PCT_IDLE ##1 st_r.run == PCT_IDLE)
      else $error("single mode kept running");
   pulse_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && st_r.delay == '0 && st_r.width != '0 && !st_r.dph_wr
      |=> st_r.pw_cnt == $past(st_r.width)
      ##1 st_r.pw_cnt == $past(st_r.width, 2) - 16'h0001)
      else $error("pulse width wrong");
   dir_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fire |-> (cross_up && attr[0]) || (cross_dn && attr[1]))
      else $error("fired against direction");
   origin_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.ctrl[PCT_CTRL_ORIGIN] |=> st_r.cnt == $past(st_r.origin))
      else $error("origin offset not loaded");
   fire_c: cover property (@(posedge hclk) disable iff (!hresetn) fire);
   cycle_c: cover property (@(posedge hclk) disable iff (!hresetn)
      fire && last_tgt && mode == PCT_CYCLE);
   ncyc_c: cover property (@(posedge hclk) disable iff (!hresetn)
      fire && mode == PCT_NCYCLE ##1 st_r.run == PCT_IDLE);
endmodule

//--- pct_pkg.sv
package pct_pkg;
   localparam int PCT_NUM_TARGETS = 42;
   localparam int PCT_IDX_W = 6;
   localparam int PCT_POS_W = 32;
   localparam int PCT_CNT_W = 16;
   // Register byte offsets.
   localparam logic [11:0] PCT_OFF_CTRL = 12'h000;
   localparam logic [11:0] PCT_OFF_WIDTH = 12'h004;
   localparam logic [11:0] PCT_OFF_DELAY = 12'h008;
   localparam logic [11:0] PCT_OFF_START = 12'h00C;
   localparam logic [11:0] PCT_OFF_END = 12'h010;
   localparam logic [11:0] PCT_OFF_ORIGIN = 12'h014;
   localparam logic [11:0] PCT_OFF_CYCLES = 12'h018;
   localparam logic [11:0] PCT_OFF_POS = 12'h01C;
   localparam logic [11:0] PCT_OFF_STATUS = 12'h020;
   localparam logic [11:0] PCT_OFF_TVAL = 12'h100;
   localparam logic [11:0] PCT_OFF_TATTR = 12'h200;
   // Control register fields.
   localparam int PCT_CTRL_EN = 0;
   localparam int PCT_CTRL_MODE = 1;
   localparam int PCT_CTRL_FLIP = 3;
   localparam int PCT_CTRL_SRC = 4;
   localparam int PCT_CTRL_ROUTE = 5;
   localparam int PCT_CTRL_DOPOL = 8;
   localparam int PCT_CTRL_ENCPOL = 14;
   localparam int PCT_CTRL_ORIGIN = 15;
   localparam logic [15:0] PCT_CTRL_RST = 16'h0000;
   localparam logic [PCT_CNT_W-1:0] PCT_WIDTH_RST = 16'h000A;
   localparam logic [PCT_CNT_W-1:0] PCT_DELAY_RST = 16'h0000;
   localparam logic [PCT_IDX_W-1:0] PCT_START_RST = 6'h01;
   localparam logic [PCT_IDX_W-1:0] PCT_END_RST = 6'h2A;

   typedef enum logic [1:0] {
      PCT_SINGLE, PCT_CYCLE, PCT_NCYCLE
   } pct_mode_t;

   typedef enum logic {PCT_IDLE, PCT_RUN} pct_run_t;

   typedef struct packed {
      logic signed [PCT_POS_W-1:0] motor_pos;
      logic signed [PCT_POS_W-1:0] ext_pos;
   } pct_pos_in_t;

   typedef struct packed {
      logic [5:0] dout;
      logic [2:0] enc_out;
   } pct_out_t;

   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
      logic hready;
      logic [31:0] hwdata;
   } pct_ahb_in_t;
endpackage

//--- pct_enc_model.sv
`timescale 1ns/1ps
// Stand-in for the encoders: the selected source walks to the goal one count
// per step, while the unused source keeps wandering so that a wrong source
// select produces stray crossings.
module pct_enc_model (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Motion command.
   input wire logic sel_ext,
   input wire logic go,
   input wire logic [1:0] slow,
   input wire logic signed [31:0] goal,
   // Encoder counts.
   output pct_pkg::pct_pos_in_t pos,
   output logic signed [31:0] act
);
   import pct_pkg::*;
   logic [1:0] div_r;
   logic signed [31:0] step;
   assign act = sel_ext ? pos.ext_pos : pos.motor_pos;
   assign step = (goal > act) ? 32'sh0000_0001 : 32'shFFFF_FFFF;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos <= '0;
         div_r <= '0;
      end else begin
         div_r <= (div_r >= slow) ? 2'h0 : div_r + 2'h1;
         if (sel_ext)
            pos.motor_pos <= pos.motor_pos + 32'sh0000_0007;
         else
            pos.ext_pos <= pos.ext_pos - 32'sh0000_0007;
         if (go && div_r >= slow && goal != act) begin
            if (sel_ext)
               pos.ext_pos <= pos.ext_pos + step;
            else
               pos.motor_pos <= pos.motor_pos + step;
         end
      end
   end
endmodule

//--- pct_top_tb.sv
`timescale 1ns/1ps
module pct_top_tb;
   import pct_pkg::*;
   logic hclk, hresetn, b_wr, hreadyout, hresp, sel_ext, go, inv, obs, obs_q;
   logic [31:0] b_addr, b_wdata, rd, hrdata;
   logic [1:0] b_trans, slow;
   logic signed [31:0] goal, act;
   logic [2:0] route;
   logic [5:0] pv;
   pct_ahb_in_t ahb_in;
   pct_pos_in_t pos;
   pct_out_t compare_output_function;
   int bad_count, total_checks, pulses, run_w, last_w, cyc, rise_cyc;
   int p0, c0, wv, seed_v;
   int lat [2];
   logic [11:0] ra [7] = '{PCT_OFF_CTRL, PCT_OFF_WIDTH, PCT_OFF_DELAY,
      PCT_OFF_START, PCT_OFF_END, PCT_OFF_STATUS, 12'h300};
   logic [31:0] rv [7] = '{0, 32'h0000_000A, 0, 1, 32'h0000_002A, 0, 0};
   assign ahb_in = '{b_addr, b_trans, b_wr, 3'h2, 1'b1, hreadyout, b_wdata};
   assign obs = ((route == 3'h7) ? compare_output_function.enc_out[0] :
      compare_output_function.dout[route - 3'h1]) ^ inv;
   pct_top u_pct_top (.hclk(hclk), .hresetn(hresetn), .ahb_in(ahb_in),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pos_in(pos), .compare_output_function(compare_output_function));
   pct_enc_model u_pct_enc_model (.hclk(hclk), .hresetn(hresetn),
      .sel_ext(sel_ext), .go(go), .slow(slow), .goal(goal), .pos(pos),
      .act(act));
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // Pulses are counted in active terms, so polarity is taken out first.
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      obs_q <= obs;
      run_w <= obs ? run_w + 1 : 0;
      if (obs && !obs_q) begin
         pulses <= pulses + 1;
         rise_cyc <= cyc;
      end
      if (!obs && obs_q) begin
         last_w <= run_w;
      end
   end
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (50000) @(posedge hclk);
      bad_count++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      finish_test();
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e, string m);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t %s: got %h exp %h", $time, m, s, e);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, logic [31:0] d);
      b_addr <= {20'h0_0000, a};
      b_wr <= w;
      b_trans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      b_trans <= 2'h0;
      b_wdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic tgt(input int n, input int v, input int a);
      bus(1, PCT_OFF_TVAL + 12'(4 * n - 4), v);
      bus(1, PCT_OFF_TATTR + 12'(4 * n - 4), a);
   endtask
   function automatic logic [31:0] mk(int m, int f, int r, int p, int ep);
      return {16'h0000, 1'b0, 1'(ep), 6'(p), 3'(r), sel_ext, 1'(f), 2'(m),
         1'b0};
   endfunction
   // Disable first so that the enable write is a clean rising edge.
   task automatic arm(input logic [31:0] c, int s, int e, int sl);
      route <= c[7:5];
      inv <= (c[7:5] == 3'h7) ? c[14] : c[c[7:5] + 4'h7];
      slow <= (sl < 0) ? 2'($urandom % 4) : 2'(sl);
      bus(1, PCT_OFF_CTRL, 0);
      bus(1, PCT_OFF_START, s);
      bus(1, PCT_OFF_END, e);
      bus(1, PCT_OFF_CTRL, c | 32'h0000_8000);
      bus(1, PCT_OFF_CTRL, c | 32'h0000_0001);
      p0 = pulses;
   endtask
   task automatic move(input int d);
      goal <= act + d;
      go <= 1'b1;
      @(posedge hclk);
      while (act != goal) @(posedge hclk);
      go <= 1'b0;
      repeat (16) @(posedge hclk);
   endtask
   task automatic endt(input string m);
      $display("Test %s done", m);
      sel_ext <= 1'($urandom % 2);
      @(posedge hclk);
   endtask
   initial begin
      hresetn = 1'b0;
      b_addr = '0;
      b_wdata = '0;
      b_trans = '0;
      b_wr = 1'b0;
      sel_ext = 1'b0;
      go = 1'b0;
      slow = '0;
      goal = '0;
      route = 3'h1;
      inv = 1'b0;
      seed_v = $urandom(34);
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 7; i++) begin
         bus(0, ra[i], 0);
         chk(rd, rv[i], "reset value");
      end
      bus(1, PCT_OFF_POS, 32'h0000_1234);
      bus(0, PCT_OFF_POS, 0);
      chk(rd, 0, "position read-only");
      endt("registers");
      // Widths stay far below the 100-count target spacing.
      wv = 1 + $urandom % 8;
      bus(1, PCT_OFF_WIDTH, wv);
      bus(1, PCT_OFF_ORIGIN, 0);
      bus(1, PCT_OFF_CYCLES, 2);
      tgt(1, 30, 1);
      tgt(2, 100, 1);
      tgt(3, 100, 3);
      tgt(4, 50, 1);
      tgt(5, 4, 1);
      arm(mk(0, 0, 1, 0, 0), 2, 3, -1);
      move(250);
      chk(pulses - p0, 1, "single stops");
      chk(last_w, wv, "pulse width");
      bus(0, PCT_OFF_POS, 0);
      chk(rd, 250, "absolute count");
      bus(0, PCT_OFF_STATUS, 0);
      chk(rd[0], 0, "single done");
      endt("single");
      arm(mk(1, 0, 1, 0, 0), 2, 3, -1);
      move(350);
      chk(pulses - p0, 3, "cycle pulses");
      bus(0, PCT_OFF_POS, 0);
      chk(rd, 50, "relative count");
      bus(1, PCT_OFF_CTRL, 0);
      bus(0, PCT_OFF_STATUS, 0);
      chk(rd, 0, "status cleared");
      endt("cycle");
      arm(mk(2, 0, 1, 0, 0), 2, 3, -1);
      move(500);
      chk(pulses - p0, 4, "n-cycle pulses");
      bus(0, PCT_OFF_CTRL, 0);
      chk(rd[0], 0, "n-cycle off");
      endt("n-cycle");
      bus(1, PCT_OFF_ORIGIN, 150);
      arm(mk(0, 0, 1, 0, 0), 2, 2, -1);
      bus(0, PCT_OFF_POS, 0);
      chk(rd, 150, "origin load");
      move(-100);
      chk(pulses - p0, 0, "falling pass");
      move(100);
      chk(pulses - p0, 1, "rising pass");
      bus(1, PCT_OFF_ORIGIN, 0);
      endt("direction");
      arm(mk(1, 0, 1, 0, 0), 2, 2, -1);
      move(100);
      repeat (40) @(posedge hclk);
      chk(pulses - p0, 1, "stop on target");
      endt("stop");
      bus(1, PCT_OFF_WIDTH, 8);
      arm(mk(1, 0, 1, 0, 0), 5, 5, 0);
      move(40);
      chk(pulses - p0, 1, "blind during pulse");
      bus(1, PCT_OFF_WIDTH, wv);
      endt("suspend");
      for (int i = 0; i < 2; i++) begin
         bus(1, PCT_OFF_DELAY, i * 5);
         arm(mk(0, 0, 1, 0, 0), 2, 2, 0);
         c0 = cyc;
         move(150);
         lat[i] = rise_cyc - c0;
      end
      chk(lat[1] - lat[0], 5, "delay shift");
      bus(1, PCT_OFF_DELAY, 0);
      endt("delay");
      for (int k = 1; k < 8; k++) begin
         pv = 6'($urandom % 64);
         arm(mk(0, 0, k, pv, pv[0]), 2, 2, -1);
         move(150);
         chk(pulses - p0, 1, "routed pulse");
         chk(compare_output_function.dout, pv, "idle levels");
      end
      endt("routing");
      arm(mk(1, 1, 7, 0, 1), 2, 2, -1);
      chk(compare_output_function.enc_out, 3'h7, "flip idle");
      move(150);
      chk(compare_output_function.enc_out, 3'h0, "flip toggled");
      move(100);
      chk(compare_output_function.enc_out, 3'h7, "flip back");
      endt("flip");
      finish_test();
   end
endmodule
